// File: stpg_core.sv
/*
  Output sequencer, pixel order decoder and test pattern generator for the data channels.
  Assumes converter words arrive on sys_clk for the slot in progress, and the link clock
  is an asynchronous pin that is sampled here to pace one output word per rising link edge.
*/
// Overview of operation
// - Mono subsample: 128-pixel kernel, even pixels only
// - Subsample reads every other pixel or colour pair, alternate lines
// - Subsample order same for even/odd kernels
// - Binning uses subsample output order
// - Colour subsample outputs pairs 0,1,4,5 through 124,125
// - Frame: overhead, then per line overhead plus readout
// - 8-bit mode drops two low bits
// - Test data only on data channels
// - Framed test data only inside start/end; training outside
// - Framed fixed/incrementing get real line CRC
// - Source chosen by prbs, synth enable, increment
// - Unframed test data continuous, no training words
// - Sync channel keeps normal timing codes
// - Patterns injected per channel, no reordering
// - Fixed mode repeats channel's own word
// - Increment each cycle, reload start after maximum
// - Framed incrementing reloads start at line start
// - Each channel PRBS seeded from its pattern
// - Unframed PRBS stream never interrupted
// - PRBS mode sends PRBS word in CRC slot
// - Training word defaults to 0x3A6
// - Line CRC polynomial, seeded per line, valid words
`timescale 1ns/1ps
module stpg_core (
  // Clock, reset, enable
  input  wire  logic                    sys_clk,
  input  wire  logic                    rst,
  input  wire  logic                    ce,
  // Wishbone slave
  input  wire  logic                    wb_cyc,
  input  wire  logic                    wb_stb,
  input  wire  logic                    wb_we,
  input  wire  logic [7:0]              wb_adr,
  input  wire  logic [31:0]             wb_dat_wr,
  input  wire  logic [3:0]              wb_sel,
  output logic       [31:0]             wb_dat_rd,
  output logic                          wb_ack,
  // Link pacing clock pin
  input  wire  logic                    link_clk,
  // Converter data
  input  wire  logic [stpg_pkg::W-1:0]  conv_data [stpg_pkg::NCH],
  // Readout addressing
  output logic       [12:0]             row_addr,
  output logic       [6:0]              kernel_addr,
  output logic       [6:0]              col_idx [stpg_pkg::NCH],
  // Output channels
  output logic       [stpg_pkg::W-1:0]  data_out [stpg_pkg::NCH],
  output stpg_pkg::stpg_sync_t          sync_kind
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FOT  = 3'b001,
    ST_ROT  = 3'b010,
    ST_LS   = 3'b011,
    ST_LINE = 3'b100,
    ST_CRC  = 3'b101,
    ST_LE   = 3'b110
  } stpg_state_t;

  function automatic logic [31:0] stpg_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : stpg_merge

  function automatic logic [9:0] stpg_crc_step(input logic [9:0] crc,
                                               input logic [9:0] d,
                                               input logic       m8);
    logic [9:0] c;
    logic       fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (m8) begin
        if (i >= 2) begin
          fb = c[7] ^ d[i];
          c  = {2'b00, c[6:0], 1'b0} ^ (fb ? {2'b00, stpg_pkg::CRC8_POLY} : 10'h000);
        end
      end else begin
        fb = c[9] ^ d[i];
        c  = {c[8:0], 1'b0} ^ (fb ? stpg_pkg::CRC10_POLY : 10'h000);
      end
    end
    return c;
  endfunction : stpg_crc_step

  function automatic logic [6:0] stpg_col(input stpg_pkg::stpg_rdmode_t m,
                                          input logic                   color,
                                          input logic                   odd_kernel,
                                          input logic [5:0]             k);
    logic [6:0] r;
    if (m == stpg_pkg::RD_NORMAL) begin
      r = odd_kernel ? {1'b0, ~k} : {1'b0, k};
    end else if (color) begin
      r = {k[5:1], 1'b0, k[0]};
    end else begin
      r = {k, 1'b0};
    end
    return r;
  endfunction : stpg_col

  // Registers
  stpg_pkg::stpg_ctrl_t ctrl;
  logic [9:0]           train;
  logic [15:0]          fot;
  logic [15:0]          rot;
  logic [12:0]          lines;
  logic [6:0]           kerns;
  logic [9:0]           seed [stpg_pkg::NCH];

  // Sequencer state
  stpg_state_t          state;
  logic [15:0]          ovh_cnt;
  logic [12:0]          row_cnt;
  logic [6:0]           kern_cnt;
  logic                 slot;
  logic                 lclk_s1;
  logic                 lclk_s2;
  logic                 lclk_s3;
  logic                 tick;
  logic                 sub;
  logic [1:0]           step;
  logic                 last_kern;
  logic                 last_row;
  logic                 test_on;
  logic                 unframed;
  logic                 wr_req;
  logic [31:0]          wmerged;
  logic [31:0]          rd_mux;

  // Link clock sampling and edge find
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
    end else if (ce) begin
      lclk_s1 <= link_clk;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
    end
  end

  assign tick      = ce & lclk_s2 & ~lclk_s3;
  assign sub       = ctrl.rdmode != stpg_pkg::RD_NORMAL;
  assign step      = sub ? 2'd2 : 2'd1;
  assign last_kern = ({1'b0, kern_cnt} + {6'd0, step}) >= {1'b0, kerns};
  assign last_row  = ({1'b0, row_cnt} + {12'd0, step}) >= {1'b0, lines};
  assign test_on   = ctrl.prbs_en | ctrl.tp_en;
  assign unframed  = test_on & ~ctrl.frame_tp;

  // Wishbone slave
  assign wr_req  = wb_cyc & wb_stb & wb_we & wb_ack;
  assign wmerged = stpg_merge(rd_mux, wb_dat_wr, wb_sel);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr[7]) begin
      rd_mux[9:0] = seed[wb_adr[6:2]];
    end else begin
      unique case (wb_adr)
        stpg_pkg::ADDR_CTRL:  rd_mux[9:0]  = ctrl;
        stpg_pkg::ADDR_TRAIN: rd_mux[9:0]  = train;
        stpg_pkg::ADDR_FOT:   rd_mux[15:0] = fot;
        stpg_pkg::ADDR_ROT:   rd_mux[15:0] = rot;
        stpg_pkg::ADDR_GEOM: begin
          rd_mux[12:0] = lines;
          rd_mux[stpg_pkg::GEOM_KERN_LSB +: 7] = kerns;
        end
        stpg_pkg::ADDR_STATUS: begin
          rd_mux[2:0] = state;
          rd_mux[stpg_pkg::STAT_BUSY_BIT] = state != ST_IDLE;
          rd_mux[stpg_pkg::STAT_ROW_LSB +: 13] = row_cnt;
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack    <= 1'b0;
      wb_dat_rd <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack    <= wb_cyc & wb_stb & ~wb_ack;
      wb_dat_rd <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl  <= stpg_pkg::CTRL_RST;
      train <= stpg_pkg::TRAIN_RST;
      fot   <= stpg_pkg::FOT_RST;
      rot   <= stpg_pkg::ROT_RST;
      lines <= stpg_pkg::LINES_RST;
      kerns <= stpg_pkg::KERN_RST;
    end else if (ce && wr_req && !wb_adr[7]) begin
      unique case (wb_adr)
        stpg_pkg::ADDR_CTRL:  ctrl  <= wmerged[9:0];
        stpg_pkg::ADDR_TRAIN: train <= wmerged[9:0];
        stpg_pkg::ADDR_FOT:   fot   <= wmerged[15:0];
        stpg_pkg::ADDR_ROT:   rot   <= wmerged[15:0];
        stpg_pkg::ADDR_GEOM: begin
          lines <= wmerged[12:0];
          kerns <= wmerged[stpg_pkg::GEOM_KERN_LSB +: 7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < stpg_pkg::NCH; i++) begin
        seed[i] <= stpg_pkg::SEED_RST;
      end
    end else if (ce && wr_req && wb_adr[7]) begin
      seed[wb_adr[6:2]] <= wmerged[9:0];
    end
  end

  // Frame sequencer, one step per rising link edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= ST_IDLE;
      ovh_cnt  <= 16'h0000;
      row_cnt  <= 13'h0000;
      kern_cnt <= 7'h00;
      slot     <= 1'b0;
    end else if (tick) begin
      unique case (state)
        ST_IDLE: begin
          ovh_cnt <= 16'h0000;
          if (ctrl.seq_en) begin
            state <= ST_FOT;
          end
        end
        ST_FOT: begin
          ovh_cnt <= ovh_cnt + 16'h0001;
          if ({1'b0, ovh_cnt} + 17'h0_0001 >= {1'b0, fot}) begin
            state   <= ST_ROT;
            ovh_cnt <= 16'h0000;
            row_cnt <= 13'h0000;
          end
        end
        ST_ROT: begin
          ovh_cnt <= ovh_cnt + 16'h0001;
          if ({1'b0, ovh_cnt} + 17'h0_0001 >= {1'b0, rot}) begin
            state <= ST_LS;
          end
        end
        ST_LS: begin
          state    <= ST_LINE;
          kern_cnt <= 7'h00;
          slot     <= 1'b0;
        end
        ST_LINE: begin
          slot <= ~slot;
          if (slot) begin
            if (last_kern) begin
              state <= ST_CRC;
            end else begin
              kern_cnt <= kern_cnt + {5'd0, step};
            end
          end
        end
        ST_CRC: state <= ST_LE;
        ST_LE: begin
          ovh_cnt <= 16'h0000;
          if (last_row) begin
            state <= ctrl.seq_en ? ST_FOT : ST_IDLE;
          end else begin
            row_cnt <= row_cnt + {11'd0, step};
            state   <= ST_ROT;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Sync channel and readout address outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_kind   <= stpg_pkg::SK_TR;
      row_addr    <= 13'h0000;
      kernel_addr <= 7'h00;
    end else if (tick) begin
      row_addr    <= row_cnt;
      kernel_addr <= kern_cnt;
      unique case (state)
        ST_LS:   sync_kind <= (row_cnt == 13'h0000) ? stpg_pkg::SK_FS : stpg_pkg::SK_LS;
        ST_LINE: sync_kind <= stpg_pkg::SK_IMG;
        ST_CRC:  sync_kind <= stpg_pkg::SK_CRC;
        ST_LE:   sync_kind <= last_row ? stpg_pkg::SK_FE : stpg_pkg::SK_LE;
        default: sync_kind <= stpg_pkg::SK_TR;
      endcase
    end
  end

  // Per-channel pattern, CRC and output word
  for (genvar c = 0; c < stpg_pkg::NCH; c++) begin : g_ch
    logic [9:0] lfsr_q;
    logic [9:0] inc_q;
    logic [9:0] crc_q;
    logic [9:0] gen_w;
    logic [9:0] tx_w;
    logic [9:0] out_w;
    logic       is_crc;
    logic       adv;

    assign gen_w = ctrl.prbs_en ? lfsr_q : (ctrl.inc_tp ? inc_q : seed[c]);
    assign adv   = tick & (unframed | (state == ST_LINE) | (state == ST_CRC & ctrl.prbs_en));

    always_comb begin
      tx_w   = train;
      is_crc = 1'b0;
      if (unframed) begin
        tx_w = gen_w;
      end else if (state == ST_LINE) begin
        tx_w = test_on ? gen_w : conv_data[c];
      end else if (state == ST_CRC) begin
        if (ctrl.prbs_en) begin
          tx_w = gen_w;
        end else begin
          is_crc = 1'b1;
        end
      end
      if (is_crc) begin
        out_w = ctrl.mode8 ? {2'b00, crc_q[7:0]} : crc_q;
      end else begin
        out_w = ctrl.mode8 ? {2'b00, tx_w[9:2]} : tx_w;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        lfsr_q <= stpg_pkg::SEED_RST;
      end else if (ce) begin
        if (!ctrl.prbs_en) begin
          lfsr_q <= seed[c];
        end else if (adv) begin
          lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        inc_q <= stpg_pkg::SEED_RST;
      end else if (ce) begin
        if (!(ctrl.tp_en && ctrl.inc_tp) || ctrl.prbs_en) begin
          inc_q <= seed[c];
        end else if (tick && ctrl.frame_tp && state == ST_LS) begin
          inc_q <= seed[c];
        end else if (adv) begin
          inc_q <= (inc_q == stpg_pkg::WORD_MAX) ? seed[c] : inc_q + 10'h001;
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        crc_q <= 10'h000;
      end else if (tick) begin
        if (state == ST_LS) begin
          crc_q <= {10{ctrl.crc_seed}};
        end else if (state == ST_LINE) begin
          crc_q <= stpg_crc_step(crc_q, tx_w, ctrl.mode8);
        end
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        data_out[c] <= stpg_pkg::TRAIN_RST;
        col_idx[c]  <= 7'h00;
      end else if (tick) begin
        data_out[c] <= out_w;
        col_idx[c]  <= stpg_col(ctrl.rdmode, ctrl.color, kern_cnt[0], {5'(c), slot});
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_line_tick;
    tick && state == ST_LINE;
  endsequence

  sequence s_ls_tick;
    tick && state == ST_LS;
  endsequence

  row_skip_a: assert property (tick && state == ST_LE && !last_row && sub
    |=> row_cnt == $past(row_cnt) + 13'h0002) else $error("row step wrong in subsample");
  mono_even_a: assert property (s_line_tick ##0 (sub && !ctrl.color)
    |=> col_idx[5][0] == 1'b0) else $error("odd pixel in mono subsample");
  color_pair_a: assert property (s_line_tick ##0 (sub && ctrl.color)
    |=> col_idx[5][1] == 1'b0) else $error("colour pair outside 0,1 mod 4");
  same_order_a: assert property (s_line_tick ##0 (ctrl.rdmode == stpg_pkg::RD_SUBSAMPLE
    && !ctrl.color && !slot) |=> col_idx[3] == 7'd12) else $error("subsample order flips");
  bin_order_a: assert property (s_line_tick ##0 (ctrl.rdmode == stpg_pkg::RD_BINNING
    && !ctrl.color && slot) |=> col_idx[3] == 7'd14) else $error("binning order differs");
  train_idle_a: assert property (tick && state == ST_ROT && !ctrl.mode8 && !unframed
    |=> data_out[0] == $past(train)) else $error("no training word outside line");
  fixed_word_a: assert property (tick && ctrl.tp_en && !ctrl.inc_tp && !ctrl.prbs_en
    && unframed && !ctrl.mode8 |=> data_out[1] == $past(seed[1])) else $error("fixed word wrong");
  inc_wrap_a: assert property (g_ch[0].adv && ctrl.tp_en && ctrl.inc_tp && !ctrl.prbs_en
    && !(ctrl.frame_tp && state == ST_LS) && g_ch[0].inc_q == stpg_pkg::WORD_MAX
    |=> g_ch[0].inc_q == $past(seed[0])) else $error("incrementer did not reload");
  low_drop_a: assert property (tick && ctrl.mode8
    |=> data_out[2][9:8] == 2'b00) else $error("8-bit word too wide");
  sync_img_a: assert property (s_line_tick
    |=> sync_kind == stpg_pkg::SK_IMG) else $error("sync not image code in line");
  line_start_a: assert property (s_ls_tick ##0 (ctrl.frame_tp && ctrl.tp_en && ctrl.inc_tp
    && !ctrl.prbs_en) |=> g_ch[0].inc_q == $past(seed[0])) else $error("no reload at line start");
  prbs_crc_a: assert property (tick && state == ST_CRC && ctrl.prbs_en && !ctrl.mode8
    |=> data_out[0] == $past(g_ch[0].lfsr_q)) else $error("CRC slot not PRBS word");
  crc_slot_a: assert property (tick && state == ST_CRC && !ctrl.prbs_en && !unframed
    && !ctrl.mode8 |=> data_out[0] == $past(g_ch[0].crc_q)) else $error("CRC slot wrong");

endmodule : stpg_core

// File: stpg_pkg.sv
/*
  Shared constants and types for the sensor output order and test pattern block.
  Assumes a 32-bit classic Wishbone register bus and 32 data channels of 10 bits.
*/
package stpg_pkg;

  // Channel geometry
  localparam int NCH = 32;
  localparam int W   = 10;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TRAIN  = 8'h04;
  localparam logic [7:0] ADDR_FOT    = 8'h08;
  localparam logic [7:0] ADDR_ROT    = 8'h0C;
  localparam logic [7:0] ADDR_GEOM   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_SEED   = 8'h80;

  // Field positions
  localparam int GEOM_KERN_LSB  = 16;
  localparam int STAT_BUSY_BIT  = 3;
  localparam int STAT_ROW_LSB   = 16;

  // Values after reset
  localparam logic [9:0]  CTRL_RST  = 10'h000;
  localparam logic [9:0]  TRAIN_RST = 10'h3A6;
  localparam logic [15:0] FOT_RST   = 16'h0010;
  localparam logic [15:0] ROT_RST   = 16'h0004;
  localparam logic [12:0] LINES_RST = 13'h1400;
  localparam logic [6:0]  KERN_RST  = 7'h50;
  localparam logic [9:0]  SEED_RST  = 10'h001;

  // Line check and pattern constants
  localparam logic [9:0] CRC10_POLY = 10'h024F;
  localparam logic [7:0] CRC8_POLY  = 8'h4D;
  localparam logic [9:0] WORD_MAX   = 10'h3FF;

  typedef enum logic [1:0] {
    RD_NORMAL    = 2'b00,
    RD_SUBSAMPLE = 2'b01,
    RD_BINNING   = 2'b10
  } stpg_rdmode_t;

  typedef enum logic [2:0] {
    SK_TR  = 3'b000,
    SK_FS  = 3'b001,
    SK_LS  = 3'b010,
    SK_IMG = 3'b011,
    SK_CRC = 3'b100,
    SK_LE  = 3'b101,
    SK_FE  = 3'b110
  } stpg_sync_t;

  typedef struct packed {
    logic         color;
    stpg_rdmode_t rdmode;
    logic         crc_seed;
    logic         mode8;
    logic         frame_tp;
    logic         inc_tp;
    logic         tp_en;
    logic         prbs_en;
    logic         seq_en;
  } stpg_ctrl_t;

endpackage : stpg_pkg

// File: stpg_rx_model.sv
/*
  Receiver-side model: free-running link pacing clock, converter words and frame counting.
  Assumes the 25 MHz bench clock; the link clock is unrelated in phase at 320 ns.
*/
`timescale 1ns/1ps
module stpg_rx_model (
  // Clock
  input  wire logic                   sys_clk,
  // Link side
  output logic                        link_clk,
  output logic [stpg_pkg::W-1:0]      conv_data [stpg_pkg::NCH],
  input  wire stpg_pkg::stpg_sync_t   sync_kind,
  output int                          fe_count
);
  logic [9:0]           cnt;
  stpg_pkg::stpg_sync_t prev;

  // Link clock paces every output word, so it runs continuously
  initial begin
    link_clk = 1'b0;
    cnt = 10'h000;
    fe_count = 0;
    prev = stpg_pkg::SK_TR;
    #7;
    forever #160 link_clk = ~link_clk;
  end

  // Converter words change every cycle
  always @(posedge sys_clk) begin
    cnt <= cnt + 10'h001;
    prev <= sync_kind;
    if (sync_kind == stpg_pkg::SK_FE && prev != stpg_pkg::SK_FE) fe_count <= fe_count + 1;
  end

  always_comb begin
    for (int c = 0; c < stpg_pkg::NCH; c++) conv_data[c] = cnt ^ 10'(c);
  end
endmodule : stpg_rx_model

// File: sensor_output_order_and_test_patterns_bench.sv
/*
  Self-checking bench for the output order and test pattern block.
  Assumes stpg_core and the receiver model; bus reads are checked from a queue.
*/
`timescale 1ns/1ps
module sensor_output_order_and_test_patterns_bench;
  logic                   sys_clk, rst, ce, wb_cyc, wb_stb, wb_we, wb_ack, link_clk;
  logic [7:0]             wb_adr;
  logic [31:0]            wb_dat_wr, wb_dat_rd;
  logic [3:0]             wb_sel;
  logic [stpg_pkg::W-1:0] conv_data [stpg_pkg::NCH];
  logic [stpg_pkg::W-1:0] data_out [stpg_pkg::NCH];
  logic [stpg_pkg::W-1:0] prev [stpg_pkg::NCH];
  logic [stpg_pkg::W-1:0] seed [stpg_pkg::NCH];
  logic [stpg_pkg::W-1:0] crc [stpg_pkg::NCH];
  logic [12:0]            row_addr;
  logic [6:0]             kernel_addr;
  logic [6:0]             col_idx [stpg_pkg::NCH];
  stpg_pkg::stpg_sync_t   sync_kind, prev_sync;
  int                     bad_count = 0, cmp_count = 0, cyc_cnt = 0, fe_count, mode = 0;
  int                     wraps = 0, f0, n;
  logic                   armed, in_line, first, csd, colr;
  logic [1:0]             rdm;
  logic [15:0]            lf = 16'h004C;
  logic [32:0]            ae;
  logic [32:0]            rq [$];

  stpg_core i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_wr(wb_dat_wr), .wb_sel(wb_sel),
    .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack), .link_clk(link_clk), .conv_data(conv_data),
    .row_addr(row_addr), .kernel_addr(kernel_addr), .col_idx(col_idx), .data_out(data_out),
    .sync_kind(sync_kind));

  stpg_rx_model i_rx (.sys_clk(sys_clk), .link_clk(link_clk), .conv_data(conv_data),
    .sync_kind(sync_kind), .fe_count(fe_count));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk32

  task automatic chkw(input logic [9:0] g, input logic [9:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chkw

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // Serial line check, most significant bit first
  function automatic logic [9:0] crc_step(input logic [9:0] r, input logic [9:0] d);
    logic fb;
    for (int i = 9; i >= 0; i--) begin
      fb = r[9] ^ d[i];
      r = {r[8:0], 1'b0};
      if (fb) r = r ^ 10'h24F;
    end
    return r;
  endfunction : crc_step

  // Classic single cycle, held until ack is sampled
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         input logic [3:0] s, input logic [31:0] e);
    rq.push_back({~w, e});
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_wr <= d;
    wb_sel <= s;
    do begin
      @(posedge sys_clk);
    end while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge sys_clk);
  endtask : wb_xfer

  // Bus answers and hang limit
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      bad_count++;
      report_and_stop();
    end
    if (wb_ack === 1'b1 && rq.size() > 0) begin
      ae = rq.pop_front();
      if (ae[32]) chk32(wb_dat_rd, ae[31:0]);
    end
  end

  // Output words, checked in modes 1 to 3 whenever channel 0 or the sync code changes
  always @(negedge sys_clk) begin
    if (data_out[0] !== prev[0] || sync_kind !== prev_sync) begin
      if ((mode == 1 || mode == 2) && armed) begin
        if (mode == 1 && prev[0] == 10'h3FF) wraps++;
        for (int c = 0; c < stpg_pkg::NCH; c++)
          chkw(data_out[c], mode == 1 ? (prev[c] == 10'h3FF ? seed[c] : prev[c] + 10'h001)
               : {prev[c][8:0], prev[c][9] ^ prev[c][6]});
      end
      if (mode == 1 || mode == 2) armed = 1'b1;
      if (mode == 3) begin
        for (int c = 0; c < stpg_pkg::NCH; c++) begin
          if (sync_kind == stpg_pkg::SK_IMG && in_line) begin
            chkw(data_out[c], first ? seed[c] : (prev[c] == 10'h3FF ? seed[c]
                 : prev[c] + 10'h001));
            crc[c] = crc_step(crc[c], data_out[c]);
            if (rdm != 2'b00)
              chkw({4'h0, col_idx[c][6:2], colr ? col_idx[c][1] : col_idx[c][0]},
                   {4'h0, 5'(c), 1'b0});
          end else if (sync_kind == stpg_pkg::SK_CRC && in_line) begin
            chkw(data_out[c], crc[c]);
          end else if (sync_kind != stpg_pkg::SK_IMG && sync_kind != stpg_pkg::SK_CRC) begin
            chkw(data_out[c], 10'h3A6);
            crc[c] = {10{csd}};
          end
        end
        if (sync_kind == stpg_pkg::SK_IMG && rdm != 2'b00)
          chkw({9'h000, row_addr[0] | kernel_addr[0]}, 10'h000);
        first = (sync_kind == stpg_pkg::SK_LS || sync_kind == stpg_pkg::SK_FS);
        if (first) in_line = 1'b1;
      end
      prev = data_out;
      prev_sync = sync_kind;
    end
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_wr = 32'h0000_0000;
    wb_sel = 4'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    for (int c = 0; c < stpg_pkg::NCH; c++) chkw(data_out[c], 10'h3A6);
    @(posedge sys_clk);
    wb_xfer(stpg_pkg::ADDR_TRAIN, 1'b0, 32'h0000_0000, 4'h0, 32'h0000_03A6);
    wb_xfer(stpg_pkg::ADDR_SEED, 1'b0, 32'h0000_0000, 4'h0, 32'h0000_0001);
    wb_xfer(8'h40, 1'b1, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000);
    wb_xfer(8'h40, 1'b0, 32'h0000_0000, 4'h0, 32'h0000_0000);
    wb_xfer(stpg_pkg::ADDR_TRAIN, 1'b1, 32'h0000_0155, 4'h1, 32'h0000_0000);
    wb_xfer(stpg_pkg::ADDR_TRAIN, 1'b0, 32'h0000_0000, 4'h0, 32'h0000_0355);
    wb_xfer(stpg_pkg::ADDR_TRAIN, 1'b1, 32'h0000_03A6, 4'hF, 32'h0000_0000);
    // Nonzero seeds per channel
    for (int c = 0; c < stpg_pkg::NCH; c++) begin
      lf = lfsr_next(lf);
      seed[c] = {lf[9:1], 1'b1};
      wb_xfer(8'(stpg_pkg::ADDR_SEED + 4 * c), 1'b1, {22'h0, seed[c]}, 4'hF, 0);
    end
    // Fixed unframed words, 10-bit then 8-bit
    for (int m = 0; m < 2; m++) begin
      wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, m ? 32'h0000_0024 : 32'h0000_0004, 4'hF, 0);
      repeat (40) @(posedge sys_clk);
      for (int c = 0; c < stpg_pkg::NCH; c++)
        chkw(data_out[c], m ? {2'b00, seed[c][9:2]} : seed[c]);
    end
    // Unframed incrementing across a wrap
    seed[0] = 10'h3FA;
    wb_xfer(stpg_pkg::ADDR_SEED, 1'b1, 32'h0000_03FA, 4'hF, 0);
    wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, 32'h0000_000C, 4'hF, 0);
    armed = 1'b0;
    mode = 1;
    repeat (8800) @(posedge sys_clk);
    mode = 0;
    chkw(10'(wraps != 0), 10'h001);
    // PRBS wins over the other selects
    wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, 32'h0000_000E, 4'hF, 0);
    armed = 1'b0;
    mode = 2;
    repeat (200) @(posedge sys_clk);
    // Clock enable low freezes the stream, which then resumes in order
    ce <= 1'b0;
    repeat (40) @(posedge sys_clk);
    ce <= 1'b1;
    repeat (200) @(posedge sys_clk);
    mode = 0;
    wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000, 4'hF, 0);
    // Framed incrementing over every readout order
    wb_xfer(stpg_pkg::ADDR_GEOM, 1'b1, 32'h0004_0004, 4'hF, 0);
    wb_xfer(stpg_pkg::ADDR_FOT, 1'b1, 32'h0000_0001, 4'hF, 0);
    wb_xfer(stpg_pkg::ADDR_ROT, 1'b1, 32'h0000_0001, 4'hF, 0);
    repeat (40) @(posedge sys_clk);
    for (int r = 0; r < 4; r++) begin
      rdm = (r == 3) ? 2'b01 : 2'(r);
      colr = (r == 3);
      csd = r[0];
      f0 = fe_count;
      in_line = 1'b0;
      mode = 3;
      wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, {22'h0, colr, rdm, csd, 6'b011101}, 4'hF, 0);
      n = 0;
      while (fe_count < f0 + 2 && n < 5000) begin
        @(posedge sys_clk);
        n++;
      end
      chkw(10'(fe_count - f0), 10'h002);
      mode = 0;
      wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, 32'h0000_0000, 4'hF, 0);
      // Let the running frame finish so the next order starts from idle
      repeat (600) @(posedge sys_clk);
    end
    // Framed PRBS frame for the CRC slot word
    wb_xfer(stpg_pkg::ADDR_CTRL, 1'b1, 32'h0000_0013, 4'hF, 0);
    repeat (800) @(posedge sys_clk);
    report_and_stop();
  end
endmodule : sensor_output_order_and_test_patterns_bench
